// ---- core/asp_baud_timer.sv ----
// 8-bit auto-reload baud timer with overflow and halved baud tick
`timescale 1ns/10ps
module asp_baud_timer #(
    parameter int unsigned W = asp_pkg::BAUD_W
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         enable_i,
    input  wire logic         tick_i,
    input  wire logic [W-1:0] reload_i,
    input  wire logic         force_i,
    output logic [W-1:0]      count_o,
    output logic              ovf_o,
    output logic              baud_o
);
    import asp_pkg::*;

    localparam logic [W-1:0] ONE = 1;
    localparam logic [W-1:0] TOP = '1;

    logic half_r;

    // count timer clocks; overflow reloads, so rate is tick/(256-reload)
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_o <= '0;
            ovf_o   <= 1'b0;
        end else if (force_i) begin
            count_o <= reload_i;
            ovf_o   <= 1'b0;
        end else if (enable_i && tick_i) begin
            if (count_o == TOP) begin
                count_o <= reload_i;
                ovf_o   <= 1'b1;
            end else begin
                count_o <= count_o + ONE;
                ovf_o   <= 1'b0;
            end
        end else begin
            ovf_o <= 1'b0;
        end
    end

    // halve the overflows into the baud tick; a forced reload restarts the phase
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            half_r <= 1'b0;
            baud_o <= 1'b0;
        end else if (force_i) begin
            half_r <= 1'b0;
            baud_o <= 1'b0;
        end else begin
            if (ovf_o) begin
                half_r <= ~half_r;
            end
            baud_o <= ovf_o && half_r;
        end
    end
endmodule

// ---- core/asp_pkg.sv ----
// constants and types shared by the serial port with timer baud
package asp_pkg;
    localparam int unsigned   BAUD_W        = 8;
    localparam logic [7:0]    ADDR_CTRL     = 8'h98;
    localparam logic [7:0]    ADDR_DATA     = 8'h99;
    localparam logic [7:0]    CTRL_RESET    = 8'h40;
    localparam logic [7:0]    DATA_RESET    = 8'h00;
    localparam logic [7:0]    UNMAPPED_READ = 8'h00;
    localparam int unsigned   BIT_MODE      = 7;
    localparam int unsigned   BIT_UNUSED    = 6;
    localparam int unsigned   BIT_MCE       = 5;
    localparam int unsigned   BIT_REN       = 4;
    localparam int unsigned   BIT_TB8       = 3;
    localparam int unsigned   BIT_RB8       = 2;
    localparam int unsigned   BIT_TI        = 1;
    localparam int unsigned   BIT_RI        = 0;
    localparam logic [3:0]    BITS_8BIT     = 4'h8;
    localparam logic [3:0]    BITS_9BIT     = 4'h9;
    localparam logic [BAUD_W-1:0] TIMER_TOP = 8'hFF;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_STOP
    } asp_tx_e;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_BITS,
        RX_STOP
    } asp_rx_e;
endpackage

// ---- core/asp_top.sv ----
// full-duplex serial port with 8/9-bit frames, control and data locations
`timescale 1ns/10ps
module asp_top (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic [7:0]                 sfr_addr_i,
    input  wire logic                       sfr_wr_i,
    input  wire logic                       sfr_rd_i,
    input  wire logic [7:0]                 sfr_wdata_i,
    output logic [7:0]                      sfr_rdata_o,
    input  wire logic                       timer_enable_i,
    input  wire logic                       timer_tick_i,
    input  wire logic [asp_pkg::BAUD_W-1:0] baud_reload_value_i,
    input  wire logic                       serial_int_enable_i,
    output logic                            serial_irq_o,
    input  wire logic                       serial_in_pin_i,
    output logic                            serial_out_pin_o
);
    import asp_pkg::*;

    // control bits
    logic              mode_r;
    logic              mce_r;
    logic              ren_r;
    logic              tb8_r;
    logic              rb8_r;
    logic              ti_r;
    logic              ri_r;
    logic [7:0]        rx_buf_r;
    // transmit side
    asp_tx_e           tx_state_r;
    logic [8:0]        tx_shift_r;
    logic [3:0]        tx_cnt_r;
    // receive side
    asp_rx_e           rx_state_r;
    logic [8:0]        rx_shift_r;
    logic [3:0]        rx_cnt_r;
    logic              rx_phase_r;
    logic              rx_meta_r;
    logic              rx_sync_r;
    logic              rx_prev_r;
    // timers
    logic [BAUD_W-1:0] tx_count_w;
    logic [BAUD_W-1:0] rx_count_w;
    logic              tx_baud_w;
    logic              rx_ovf_w;
    // events
    logic              wr_ctrl_w;
    logic              wr_data_w;
    logic              start_det_w;
    logic              rx_sample_w;
    logic              stop_seen_w;
    logic              rx_ninth_w;
    logic              rx_load_w;
    logic              ti_set_w;
    logic [3:0]        nbits_w;
    logic [7:0]        ctrl_view_w;
    assign wr_ctrl_w   = sfr_wr_i && (sfr_addr_i == ADDR_CTRL);
    assign wr_data_w   = sfr_wr_i && (sfr_addr_i == ADDR_DATA);
    assign nbits_w     = mode_r ? BITS_9BIT : BITS_8BIT;
    assign ctrl_view_w = {mode_r, 1'b1, mce_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};
    // tx timer follows the visible counter, rx timer is the hidden copy
    asp_baud_timer #(.W(BAUD_W)) u_tx_timer (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .enable_i (timer_enable_i),
        .tick_i   (timer_tick_i),
        .reload_i (baud_reload_value_i),
        .force_i  (1'b0),
        .count_o  (tx_count_w),
        .ovf_o    (),
        .baud_o   (tx_baud_w)
    );
    // same enable and reload as the tx timer, plus reload on start
    asp_baud_timer #(.W(BAUD_W)) u_rx_timer (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .enable_i (timer_enable_i),
        .tick_i   (timer_tick_i),
        .reload_i (baud_reload_value_i),
        .force_i  (start_det_w),
        .count_o  (rx_count_w),
        .ovf_o    (rx_ovf_w),
        .baud_o   ()
    );
    // pin synchroniser; only rx_sync_r onward is looked at
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end else begin
            rx_meta_r <= serial_in_pin_i;
            rx_sync_r <= rx_meta_r;
            rx_prev_r <= rx_sync_r;
        end
    end
    // falling edge while idle and enabled marks a start
    assign start_det_w = (rx_state_r == RX_IDLE) && ren_r && rx_prev_r && !rx_sync_r;
    // overflows come at twice baud; every second one is a bit centre
    assign rx_sample_w = rx_ovf_w && rx_phase_r;
    assign stop_seen_w = (rx_state_r == RX_STOP) && rx_sample_w;
    assign rx_ninth_w  = mode_r ? rx_shift_r[8] : rx_sync_r;
    // load needs a free buffer; check bit is stop (8-bit) or ninth (9-bit)
    assign rx_load_w   = stop_seen_w && !ri_r && (!mce_r || rx_ninth_w);
    assign ti_set_w    = (tx_state_r == TX_DATA) && tx_baud_w && (tx_cnt_r == nbits_w);
    // control register; hardware set beats a software clear in the same cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_r <= CTRL_RESET[BIT_MODE];
            mce_r  <= CTRL_RESET[BIT_MCE];
            ren_r  <= CTRL_RESET[BIT_REN];
            tb8_r  <= CTRL_RESET[BIT_TB8];
        end else if (wr_ctrl_w) begin
            mode_r <= sfr_wdata_i[BIT_MODE];
            mce_r  <= sfr_wdata_i[BIT_MCE];
            ren_r  <= sfr_wdata_i[BIT_REN];
            tb8_r  <= sfr_wdata_i[BIT_TB8];
        end
    end

    // done flags are cleared only by software writes
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ti_r  <= CTRL_RESET[BIT_TI];
            ri_r  <= CTRL_RESET[BIT_RI];
            rb8_r <= CTRL_RESET[BIT_RB8];
        end else begin
            if (ti_set_w) begin
                ti_r <= 1'b1;
            end else if (wr_ctrl_w) begin
                ti_r <= sfr_wdata_i[BIT_TI];
            end
            if (rx_load_w) begin
                ri_r  <= 1'b1;
                rb8_r <= rx_ninth_w;
            end else if (wr_ctrl_w) begin
                ri_r  <= sfr_wdata_i[BIT_RI];
                rb8_r <= sfr_wdata_i[BIT_RB8];
            end
        end
    end

    // receive buffer is separate from the shifter so a new frame can start
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_buf_r <= DATA_RESET;
        end else if (rx_load_w) begin
            rx_buf_r <= rx_shift_r[7:0];
        end
    end

    // register reads, answered one cycle later; transmit data is not visible
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sfr_rdata_o <= UNMAPPED_READ;
        end else if (sfr_rd_i) begin
            if (sfr_addr_i == ADDR_CTRL) begin
                sfr_rdata_o <= ctrl_view_w;
            end else if (sfr_addr_i == ADDR_DATA) begin
                sfr_rdata_o <= rx_buf_r;
            end else begin
                sfr_rdata_o <= UNMAPPED_READ;
            end
        end
    end

    // interrupt request is a level, held while either flag stands
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            serial_irq_o <= 1'b0;
        end else begin
            serial_irq_o <= serial_int_enable_i && (ti_r || ri_r);
        end
    end

    // transmitter; a write during a frame restarts it with the new byte
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_state_r       <= TX_IDLE;
            tx_shift_r       <= '0;
            tx_cnt_r         <= '0;
            serial_out_pin_o <= 1'b1;
        end else if (wr_data_w) begin
            tx_shift_r       <= {tb8_r, sfr_wdata_i};
            tx_cnt_r         <= '0;
            tx_state_r       <= TX_START;
            serial_out_pin_o <= 1'b1;
        end else if (tx_baud_w) begin
            unique case (tx_state_r)
                TX_IDLE: begin
                    serial_out_pin_o <= 1'b1;
                end
                TX_START: begin
                    serial_out_pin_o <= 1'b0;
                    tx_state_r       <= TX_DATA;
                end
                TX_DATA: begin
                    if (tx_cnt_r == nbits_w) begin
                        serial_out_pin_o <= 1'b1;
                        tx_state_r       <= TX_STOP;
                    end else begin
                        serial_out_pin_o <= tx_shift_r[0];
                        tx_shift_r       <= {1'b0, tx_shift_r[8:1]};
                        tx_cnt_r         <= tx_cnt_r + 4'h1;
                    end
                end
                TX_STOP: begin
                    tx_state_r <= TX_IDLE;
                end
            endcase
        end
    end

    // receiver; clearing the enable drops a frame in progress
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_state_r <= RX_IDLE;
            rx_shift_r <= '0;
            rx_cnt_r   <= '0;
            rx_phase_r <= 1'b0;
        end else if (!ren_r) begin
            rx_state_r <= RX_IDLE;
            rx_phase_r <= 1'b0;
        end else if (start_det_w) begin
            rx_state_r <= RX_START;
            rx_phase_r <= 1'b1;
            rx_cnt_r   <= '0;
        end else if (rx_ovf_w) begin
            rx_phase_r <= ~rx_phase_r;
            unique case (rx_state_r)
                RX_IDLE: begin
                    rx_phase_r <= 1'b0;
                end
                RX_START: begin
                    // half a bit in: a high line was only a glitch
                    rx_phase_r <= 1'b0;
                    rx_state_r <= rx_sync_r ? RX_IDLE : RX_BITS;
                end
                RX_BITS: begin
                    if (rx_phase_r) begin
                        rx_shift_r[rx_cnt_r] <= rx_sync_r;
                        rx_cnt_r             <= rx_cnt_r + 4'h1;
                        if (rx_cnt_r == nbits_w - 4'h1) begin
                            rx_state_r <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_phase_r) begin
                        rx_state_r <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    // checks on the design's own behaviour
    property p_load_data;
        @(posedge clk_i) disable iff (rst_i)
        rx_load_w |=> ri_r && rx_buf_r == $past(rx_shift_r[7:0]) && rb8_r == $past(rx_ninth_w);
    endproperty
    a_load_data: assert property (p_load_data) else $error("receive load lost");
    property p_overrun;
        @(posedge clk_i) disable iff (rst_i)
        stop_seen_w && ri_r && !wr_ctrl_w |=> $stable(rx_buf_r) && ri_r;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun changed buffer");
    property p_mce_block;
        @(posedge clk_i) disable iff (rst_i)
        stop_seen_w && mce_r && !rx_ninth_w && !ri_r && !wr_ctrl_w |=> !ri_r;
    endproperty
    a_mce_block: assert property (p_mce_block) else $error("check bit ignored");
    property p_ti_stop;
        @(posedge clk_i) disable iff (rst_i)
        ti_set_w && !wr_data_w |=> ti_r && serial_out_pin_o && tx_state_r == TX_STOP;
    endproperty
    a_ti_stop: assert property (p_ti_stop) else $error("done flag not at stop");
    property p_flag_hold;
        @(posedge clk_i) disable iff (rst_i)
        ti_r && !wr_ctrl_w |=> ti_r;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by hardware");
    property p_irq;
        @(posedge clk_i) disable iff (rst_i)
        ##1 serial_irq_o == ($past(serial_int_enable_i) && ($past(ti_r) || $past(ri_r)));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request wrong");
    property p_unused_bit;
        @(posedge clk_i) disable iff (rst_i)
        sfr_rd_i && sfr_addr_i == ADDR_CTRL |=> sfr_rdata_o[BIT_UNUSED];
    endproperty
    a_unused_bit: assert property (p_unused_bit) else $error("bit 6 read low");
    property p_read_buf;
        @(posedge clk_i) disable iff (rst_i)
        sfr_rd_i && sfr_addr_i == ADDR_DATA |=> sfr_rdata_o == $past(rx_buf_r);
    endproperty
    a_read_buf: assert property (p_read_buf) else $error("data read not buffer");
    property p_start_reload;
        @(posedge clk_i) disable iff (rst_i)
        start_det_w |=> rx_count_w == $past(baud_reload_value_i) && rx_state_r == RX_START;
    endproperty
    a_start_reload: assert property (p_start_reload) else $error("no reload on start");
    property p_ren_off;
        @(posedge clk_i) disable iff (rst_i)
        !ren_r |=> rx_state_r == RX_IDLE && !rx_load_w;
    endproperty
    a_ren_off: assert property (p_ren_off) else $error("receive while disabled");

    c_rx_load: cover property (@(posedge clk_i) disable iff (rst_i) rx_load_w && mode_r);
    c_overrun: cover property (@(posedge clk_i) disable iff (rst_i) stop_seen_w && ri_r);
    c_tx_done: cover property (@(posedge clk_i) disable iff (rst_i) ti_set_w);
    c_glitch:  cover property (@(posedge clk_i) disable iff (rst_i)
        rx_state_r == RX_START && rx_ovf_w && rx_sync_r);
endmodule

// ---- verification/asp_far_node.sv ----
// far serial node: sends frames into the port and captures its frames
`timescale 1ns/10ps
module asp_far_node (
    input  wire logic       clk_i,
    input  wire logic [7:0] reload_i,
    input  wire logic       nine_i,
    input  wire logic       line_i,
    output logic            line_o
);
    int         bit_cyc;
    int         low_run;
    int         last_run;
    int         start_len;
    int         got_count;
    logic [7:0] got_data;
    logic       got_ninth;
    logic       got_stop;

    // bit time in clocks: two overflows of the reload timer
    always_comb bit_cyc = 2 * (256 - int'(reload_i));

    // length of each low run, so a start bit can be timed to the clock
    always @(posedge clk_i) begin
        if (line_i === 1'b0) begin
            low_run <= low_run + 1;
        end else begin
            if (low_run != 0) last_run <= low_run;
            low_run <= 0;
        end
    end

    // one frame toward the port; skew shifts it against the port's timer
    task automatic send(input logic [7:0] d, input logic ninth, input logic stop, input int skew);
        repeat (skew) @(posedge clk_i);
        line_o <= 1'b0;
        repeat (bit_cyc) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            line_o <= d[i];
            repeat (bit_cyc) @(posedge clk_i);
        end
        if (nine_i) begin
            line_o <= ninth;
            repeat (bit_cyc) @(posedge clk_i);
        end
        line_o <= stop;
        repeat (bit_cyc) @(posedge clk_i);
        line_o <= 1'b1;
        repeat (bit_cyc) @(posedge clk_i);
    endtask

    // capture: sample at mid-bit, start length read once bit 0 is reached
    initial begin
        line_o = 1'b1;
        got_count = 0;
        forever begin
            @(negedge line_i);
            repeat (bit_cyc / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
                repeat (bit_cyc) @(posedge clk_i);
                got_data[i] = line_i;
                if (i == 0) start_len = last_run;
            end
            if (nine_i) begin
                repeat (bit_cyc) @(posedge clk_i);
                got_ninth = line_i;
            end
            repeat (bit_cyc) @(posedge clk_i);
            got_stop = line_i;
            got_count++;
        end
    end
endmodule

// ---- verification/tb_top.sv ----
// register-level testbench of the serial port against a far node model
`timescale 1ns/10ps
module tb_top;
    import asp_pkg::*;
    logic       clk_i;
    logic       rst_i;
    logic       wr;
    logic       rd_s;
    logic       t_en;
    logic       int_en;
    logic       ser_in;
    logic       ser_out;
    logic       irq;
    logic       far_nine;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] reload;
    int         fail_count;
    int         compares;

    asp_top dut_u (
        .clk_i               (clk_i),
        .rst_i               (rst_i),
        .sfr_addr_i          (addr),
        .sfr_wr_i            (wr),
        .sfr_rd_i            (rd_s),
        .sfr_wdata_i         (wdata),
        .sfr_rdata_o         (rdata),
        .timer_enable_i      (t_en),
        .timer_tick_i        (1'b1),
        .baud_reload_value_i (reload),
        .serial_int_enable_i (int_en),
        .serial_irq_o        (irq),
        .serial_in_pin_i     (ser_in),
        .serial_out_pin_o    (ser_out)
    );

    asp_far_node far_u (
        .clk_i    (clk_i),
        .reload_i (reload),
        .nine_i   (far_nine),
        .line_i   (ser_out),
        .line_o   (ser_in)
    );

    // 250 MHz clock
    always #2 clk_i = ~clk_i;

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one-cycle strobes; request held from one edge to the next
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask

    // read data is registered at the taking edge, looked at one edge later
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_i);
        rd_s <= 1'b0;
        @(posedge clk_i);
        chk(what, rdata, exp);
    endtask

    task automatic irq_chk(input logic e);
        repeat (3) @(posedge clk_i);
        chk("irq", {7'h00, irq}, {7'h00, e});
    endtask

    // send a byte, then read control while the far node is mid stop bit
    task automatic tx_chk(input logic [7:0] d, input logic ninth);
        int n;
        int k;
        // clear the done flag first so the flag read below proves a fresh set
        wr_reg(ADDR_CTRL, {far_nine, 3'b000, ninth, 3'b000});
        repeat (80) @(posedge clk_i);
        n = far_u.got_count;
        wr_reg(ADDR_DATA, d);
        k = 0;
        while (far_u.got_count == n && k < 3000) begin
            @(posedge clk_i);
            k++;
        end
        chk("tx frame", 8'(far_u.got_count - n), 8'h01);
        rchk("tx done", ADDR_CTRL, {CTRL_RESET[7:2] | {far_nine, 3'b000, ninth, 1'b0}, 2'b10});
        chk("tx data", far_u.got_data, d);
        chk("tx stop", {7'h00, far_u.got_stop}, 8'h01);
        if (far_nine) chk("tx ninth", {7'h00, far_u.got_ninth}, {7'h00, ninth});
        chk("start len", 8'(far_u.start_len), 8'(2 * (256 - int'(reload))));
        repeat (2 * (256 - int'(reload))) @(posedge clk_i);
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog: the whole run needs well under 10000 cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        fail_count++;
        close_out();
    end

    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        wr = 1'b0;
        rd_s = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        t_en = 1'b1;
        int_en = 1'b1;
        far_nine = 1'b0;
        reload = 8'hF0;
        fail_count = 0;
        compares = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("pin idle", {7'h00, ser_out}, 8'h01);
        rchk("ctrl reset", ADDR_CTRL, CTRL_RESET);
        rchk("data reset", ADDR_DATA, DATA_RESET);
        rchk("unmapped", 8'h9A, UNMAPPED_READ);
        wr_reg(ADDR_CTRL, 8'h00);
        rchk("bit6 stuck", ADDR_CTRL, 8'h40);
        wr_reg(ADDR_CTRL, 8'hBF);
        rchk("ctrl all", ADDR_CTRL, 8'hFF);
        irq_chk(1'b1);
        int_en <= 1'b0;
        irq_chk(1'b0);
        int_en <= 1'b1;
        wr_reg(ADDR_CTRL, 8'h00);
        irq_chk(1'b0);
        $display("test registers done");
        // 8-bit transmit at two baud rates, data location still reads receive side
        tx_chk(8'hA5, 1'b0);
        rchk("data not tx", ADDR_DATA, 8'h00);
        reload <= 8'hF8;
        tx_chk(8'h3B, 1'b0);
        // 9-bit transmit, ninth bit from control bit 3
        far_nine <= 1'b1;
        wr_reg(ADDR_CTRL, 8'h88);
        tx_chk(8'h81, 1'b1);
        wr_reg(ADDR_CTRL, 8'h80);
        tx_chk(8'h81, 1'b0);
        $display("test transmit done");
        // 8-bit receive, then an overrun while the done flag stands
        far_nine <= 1'b0;
        wr_reg(ADDR_CTRL, 8'h10);
        far_u.send(8'h5A, 1'b0, 1'b1, 3);
        rchk("rx ctrl", ADDR_CTRL, 8'h55);
        rchk("rx data", ADDR_DATA, 8'h5A);
        irq_chk(1'b1);
        rchk("rx flag kept", ADDR_CTRL, 8'h55);
        far_u.send(8'h11, 1'b0, 1'b1, 5);
        rchk("ovr ctrl", ADDR_CTRL, 8'h55);
        rchk("ovr data", ADDR_DATA, 8'h5A);
        // stop-level check in 8-bit mode
        wr_reg(ADDR_CTRL, 8'h30);
        far_u.send(8'h22, 1'b0, 1'b0, 1);
        rchk("bad stop ctrl", ADDR_CTRL, 8'h70);
        rchk("bad stop data", ADDR_DATA, 8'h5A);
        wr_reg(ADDR_CTRL, 8'h10);
        far_u.send(8'h33, 1'b0, 1'b0, 2);
        rchk("stop to rb8", ADDR_CTRL, 8'h51);
        rchk("low stop data", ADDR_DATA, 8'h33);
        $display("test receive 8 done");
        // 9-bit receive with address filtering
        far_nine <= 1'b1;
        wr_reg(ADDR_CTRL, 8'hB0);
        far_u.send(8'h44, 1'b0, 1'b1, 0);
        rchk("data byte ctrl", ADDR_CTRL, 8'hF0);
        rchk("data byte data", ADDR_DATA, 8'h33);
        far_u.send(8'h07, 1'b1, 1'b0, 7);
        rchk("addr ctrl", ADDR_CTRL, 8'hF5);
        rchk("addr data", ADDR_DATA, 8'h07);
        $display("test receive 9 done");
        // receiver off
        far_nine <= 1'b0;
        wr_reg(ADDR_CTRL, 8'h00);
        far_u.send(8'h66, 1'b0, 1'b1, 4);
        rchk("off ctrl", ADDR_CTRL, 8'h40);
        rchk("off data", ADDR_DATA, 8'h07);
        $display("test receive off done");
        close_out();
    end
endmodule
